// File: include/bus_ctl_pkg.sv
// Purpose: shared constants for the minimum-mode bus control block
// Assumes: one half processor state per mclk cycle (two cycles per T state)
// Notes:   status codes are {io_sel, direction, status_zero}
package bus_ctl_pkg;

	// cycle kinds requested by the core side
	typedef enum logic [2:0] {
		KIND_INTERRUPT_ACK_STROBE_N,
		KIND_IO_READ,
		KIND_IO_WRITE,
		KIND_HALT,
		KIND_CODE,
		KIND_MEM_READ,
		KIND_MEM_WRITE,
		KIND_PASSIVE
	} cycle_kind_t;

	// three-line status patterns
	localparam logic [2:0] STAT_INTERRUPT_ACK_STROBE_N      = 3'h4;
	localparam logic [2:0] STAT_IO_READ   = 3'h5;
	localparam logic [2:0] STAT_IO_WRITE  = 3'h6;
	localparam logic [2:0] STAT_HALT      = 3'h7;
	localparam logic [2:0] STAT_CODE      = 3'h0;
	localparam logic [2:0] STAT_MEM_READ  = 3'h1;
	localparam logic [2:0] STAT_MEM_WRITE = 3'h2;
	localparam logic [2:0] STAT_PASSIVE   = 3'h3;

	// field positions inside a status pattern
	localparam int STAT_IO_BIT  = 2;
	localparam int STAT_DIR_BIT = 1;
	localparam int STAT_S0_BIT  = 0;

	// level shown by every control line while floated
	localparam logic FLOAT_LEVEL = 1'b1;

endpackage : bus_ctl_pkg

// File: design/status_encoder.sv
// Purpose: map a requested cycle kind to its three-line status pattern
// Assumes: kind comes from logic on the same clock
// Notes:   pattern is registered so status outputs come from flip-flops
`timescale 1ns/1ps
module status_encoder (
	// clock and reset
	input  wire logic                      mclk,
	input  wire logic                      reset_n,
	// control
	input  wire logic                      load,
	input  wire bus_ctl_pkg::cycle_kind_t  kind,
	// pattern out
	output logic [2:0]                     pattern_reg
);

	logic [2:0] pattern_next;
	logic [2:0] decoded;

	// R17: encode ack and io read
	// R18: remaining status patterns
	always_comb begin
		decoded = bus_ctl_pkg::STAT_PASSIVE;
		unique case (kind)
			bus_ctl_pkg::KIND_INTERRUPT_ACK_STROBE_N:      decoded = bus_ctl_pkg::STAT_INTERRUPT_ACK_STROBE_N;
			bus_ctl_pkg::KIND_IO_READ:   decoded = bus_ctl_pkg::STAT_IO_READ;
			bus_ctl_pkg::KIND_IO_WRITE:  decoded = bus_ctl_pkg::STAT_IO_WRITE;
			bus_ctl_pkg::KIND_HALT:      decoded = bus_ctl_pkg::STAT_HALT;
			bus_ctl_pkg::KIND_CODE:      decoded = bus_ctl_pkg::STAT_CODE;
			bus_ctl_pkg::KIND_MEM_READ:  decoded = bus_ctl_pkg::STAT_MEM_READ;
			bus_ctl_pkg::KIND_MEM_WRITE: decoded = bus_ctl_pkg::STAT_MEM_WRITE;
			bus_ctl_pkg::KIND_PASSIVE:   decoded = bus_ctl_pkg::STAT_PASSIVE;
		endcase
	end

	assign pattern_next = load ? decoded : pattern_reg;

	// hold pattern between loads
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pattern_reg <= bus_ctl_pkg::STAT_PASSIVE;
		end else begin
			pattern_reg <= pattern_next;
		end
	end

endmodule : status_encoder

// File: design/min_mode_bus_control.sv
// Purpose: minimum-mode local bus strobes, status and hold handshake
// Assumes: each T state is two mclk cycles, high phase then low phase
// Notes:   floated lines are given as output enable low, level one
//
// What this block does
// R1: active only with mode select high
// R2: io select valid from prior T4; this block drives it valid from T1
// R3: float control lines high during hold
// R4: write strobe low in T2 T3 Tw
// R5: ack strobe low in T2 T3 Tw
// R6: latch pulse in low phase of T1
// R7: direction high transmit, low receive
// R8: direction timed like io select
// R9: enable asserted in every bus cycle
// R10: read enable mid T2 to mid T4
// R11: write enable start T2 to mid T4
// R12: other master holds request while needed
// R13: grant mid T4 or idle, float bus
// R14: drop grant when request low
// R15: drive again only for next cycle
// R16: request arrives already synchronised
// R17: encode ack and io read patterns
// R18: decode remaining six status patterns
// R19: read strobe low in T2 T3 Tw
`timescale 1ns/1ps
module min_mode_bus_control (
	// clock and reset
	input  wire logic                      mclk,
	input  wire logic                      reset_n,
	// configuration strap
	input  wire logic                      min_max_mode_select,
	// core side cycle request
	input  wire logic                      cycle_request,
	input  wire bus_ctl_pkg::cycle_kind_t  cycle_kind,
	input  wire logic                      ready,
	output logic                           cycle_accept,
	output logic                           cycle_done,
	// hold handshake
	input  wire logic                      hold_request,
	output logic                           bus_hold_grant,
	// control lines, level and enable
	output logic                           io_mem_select,
	output logic                           io_mem_select_oe,
	output logic                           write_strobe_n,
	output logic                           write_strobe_n_oe,
	output logic                           read_strobe_n,
	output logic                           read_strobe_n_oe,
	output logic                           interrupt_ack_strobe_n,
	output logic                           transceiver_direction,
	output logic                           transceiver_direction_oe,
	output logic                           transceiver_output_enable_n,
	output logic                           transceiver_output_enable_n_oe,
	output logic                           status_zero_line,
	output logic                           status_zero_line_oe,
	output logic                           address_latch_pulse
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_T1,
		ST_T2,
		ST_T3,
		ST_TW,
		ST_T4,
		ST_HOLD
	} tstate_t;

	tstate_t    state_reg, state_next;
	logic       phase_reg;        // 0 high phase, 1 low phase
	logic       phase_next;
	logic       is_write_reg, is_write_next;
	logic       is_read_reg, is_read_next;
	logic       is_ack_reg, is_ack_next;
	logic       active_reg, active_next;  // status valid window
	logic [2:0] pattern_reg;
	logic       load_pattern;
	logic       min_mode;
	logic       start_cycle;
	logic       grant_now;
	logic       floated;
	logic       kind_write, kind_read, kind_ack, kind_bus;
	logic       den_on_reg, den_on_next;
	logic       strobe_on;
	logic       float_keep_reg, float_keep_next;  // floated after a hold

	// R1: only in minimum mode
	assign min_mode = min_max_mode_select;

	// R16: request used on the clock directly, no synchroniser
	// R13: grant at a T4 or idle boundary at mid state
	assign grant_now = min_mode && hold_request && phase_reg &&
		(state_reg == ST_T4 || state_reg == ST_IDLE);

	// R15: leave idle for T1 only when a new cycle is wanted
	assign start_cycle = min_mode && cycle_request && !hold_request &&
		phase_reg && (state_reg == ST_IDLE || state_reg == ST_T4);
	assign cycle_accept = start_cycle;
	assign load_pattern = start_cycle;

	// classify the requested kind
	assign kind_write = (cycle_kind == bus_ctl_pkg::KIND_IO_WRITE) ||
		(cycle_kind == bus_ctl_pkg::KIND_MEM_WRITE);
	assign kind_read = (cycle_kind == bus_ctl_pkg::KIND_IO_READ) ||
		(cycle_kind == bus_ctl_pkg::KIND_MEM_READ) ||
		(cycle_kind == bus_ctl_pkg::KIND_CODE);
	assign kind_ack = (cycle_kind == bus_ctl_pkg::KIND_INTERRUPT_ACK_STROBE_N);
	assign kind_bus = kind_write || kind_read || kind_ack;

	status_encoder u_status (
		.mclk        (mclk),
		.reset_n     (reset_n),
		.load        (load_pattern),
		.kind        (cycle_kind),
		.pattern_reg (pattern_reg)
	);

	// state sequencing, two phases per T state
	always_comb begin
		state_next = state_reg;
		phase_next = ~phase_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (grant_now) begin
					state_next = ST_HOLD;
				end else if (start_cycle) begin
					state_next = ST_T1;
				end
			end
			ST_T1: begin
				if (phase_reg) begin
					state_next = ST_T2;
				end
			end
			ST_T2: begin
				if (phase_reg) begin
					state_next = ST_T3;
				end
			end
			ST_T3, ST_TW: begin
				if (phase_reg) begin
					state_next = ready ? ST_T4 : ST_TW;
				end
			end
			ST_T4: begin
				if (grant_now) begin
					state_next = ST_HOLD;
				end else if (start_cycle) begin
					state_next = ST_T1;
				end else if (phase_reg) begin
					state_next = ST_IDLE;
				end
			end
			// R14: release when request seen low
			ST_HOLD: begin
				if (!hold_request && phase_reg) begin
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	assign cycle_done = (state_reg == ST_T4) && !phase_reg;

	// R2: status valid from T1 through final T4
	// R8: direction shares the same window
	assign active_next = start_cycle ? 1'b1 :
		((state_reg == ST_T4 && phase_reg) || grant_now) ? 1'b0 :
		active_reg;

	assign is_write_next = start_cycle ? (kind_write && kind_bus) :
		is_write_reg;
	assign is_read_next  = start_cycle ? kind_read : is_read_reg;
	assign is_ack_next   = start_cycle ? kind_ack : is_ack_reg;

	// R10: read and ack enable from mid T2 to mid T4
	// R11: write enable from start T2 to mid T4
	// R9: every bus cycle drives enable
	assign den_on_next =
		(state_next == ST_T2 && phase_next == 1'b0 && is_write_next) ||
		(state_next == ST_T2 && phase_next == 1'b1 &&
			(is_write_next || is_read_next || is_ack_next)) ||
		((state_next == ST_T3 || state_next == ST_TW) && den_on_reg) ||
		(state_next == ST_T4 && phase_next == 1'b0 && den_on_reg);

	// sequencer registers
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg    <= ST_IDLE;
			phase_reg    <= 1'b0;
			active_reg   <= 1'b0;
			is_write_reg <= 1'b0;
			is_read_reg  <= 1'b0;
			is_ack_reg   <= 1'b0;
			den_on_reg   <= 1'b0;
			float_keep_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			phase_reg    <= phase_next;
			active_reg   <= active_next;
			is_write_reg <= is_write_next;
			is_read_reg  <= is_read_next;
			is_ack_reg   <= is_ack_next;
			den_on_reg   <= den_on_next;
			float_keep_reg <= float_keep_next;
		end
	end

	// grant also serves as float request for all control lines that have an output enable
	assign bus_hold_grant = (state_reg == ST_HOLD);
	// R15: stay floated after a hold until the next cycle is taken;
	// the hold side wins, so a late accept cannot unfloat early
	assign float_keep_next = bus_hold_grant ? 1'b1 :
		start_cycle ? 1'b0 : float_keep_reg;
	assign floated = bus_hold_grant || float_keep_reg || !min_mode;

	// strobes cover T2, T3 and wait states
	assign strobe_on = (state_reg == ST_T2 || state_reg == ST_T3 ||
		state_reg == ST_TW);

	// R4: write strobe
	assign write_strobe_n = floated ? bus_ctl_pkg::FLOAT_LEVEL :
		!(strobe_on && is_write_reg);
	// R19: read strobe
	assign read_strobe_n = floated ? bus_ctl_pkg::FLOAT_LEVEL :
		!(strobe_on && is_read_reg);
	// R5: acknowledge strobe, never floated
	assign interrupt_ack_strobe_n = !(min_mode && strobe_on && is_ack_reg);

	// R6: latch pulse in second half of T1
	assign address_latch_pulse = min_mode && (state_reg == ST_T1) &&
		phase_reg;

	// R3: floated lines read as logic one
	// R7: direction bit from pattern
	assign io_mem_select = floated ? bus_ctl_pkg::FLOAT_LEVEL :
		(active_reg ? pattern_reg[bus_ctl_pkg::STAT_IO_BIT] : 1'b0);
	assign transceiver_direction = floated ? bus_ctl_pkg::FLOAT_LEVEL :
		(active_reg ? pattern_reg[bus_ctl_pkg::STAT_DIR_BIT] : 1'b1);
	assign status_zero_line = floated ? bus_ctl_pkg::FLOAT_LEVEL :
		(active_reg ? pattern_reg[bus_ctl_pkg::STAT_S0_BIT] : 1'b1);
	assign transceiver_output_enable_n = floated ?
		bus_ctl_pkg::FLOAT_LEVEL : !den_on_reg;

	// output enables drop while floated
	assign io_mem_select_oe               = !floated;
	assign write_strobe_n_oe              = !floated;
	assign read_strobe_n_oe               = !floated;
	assign transceiver_direction_oe       = !floated;
	assign transceiver_output_enable_n_oe = !floated;
	assign status_zero_line_oe            = !floated;

	// R3: select and write strobe undriven and high, status zero high during grant
	a_float_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		bus_hold_grant |-> !io_mem_select_oe && !write_strobe_n_oe &&
		io_mem_select && write_strobe_n && status_zero_line)
		else $error("control lines driven during hold");
	// R4: write strobe three phases after accept
	a_write_start: assert property (@(posedge mclk) disable iff (!reset_n)
		(start_cycle && kind_write && min_mode) |-> ##3 !write_strobe_n)
		else $error("write strobe late");
	// R6: latch pulse one cycle long after accept
	a_latch_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
		start_cycle |-> ##2 address_latch_pulse ##1 !address_latch_pulse)
		else $error("latch pulse wrong");
	// R11: write enable at start of T2
	a_write_den: assert property (@(posedge mclk) disable iff (!reset_n)
		(start_cycle && kind_write && min_mode) |->
		##2 transceiver_output_enable_n ##1 !transceiver_output_enable_n)
		else $error("write enable timing");
	// R10: read enable at mid T2
	a_read_den: assert property (@(posedge mclk) disable iff (!reset_n)
		(start_cycle && kind_read && min_mode) |->
		##3 transceiver_output_enable_n ##1 !transceiver_output_enable_n)
		else $error("read enable timing");
	// R13: grant follows request at mid T4 or idle
	a_grant_time: assert property (@(posedge mclk) disable iff (!reset_n)
		grant_now |=> bus_hold_grant)
		else $error("grant not issued");
	// R14: grant drops after request low
	a_grant_drop: assert property (@(posedge mclk) disable iff (!reset_n)
		(bus_hold_grant && !hold_request) |-> ##[1:2] !bus_hold_grant)
		else $error("grant held after release");
	// R2: select stable from T2 into T3
	a_select_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		(state_reg == ST_T2 && !floated) |=> $stable(io_mem_select))
		else $error("select changed in cycle");
	// R5: ack strobe with ack status
	a_ack_status: assert property (@(posedge mclk) disable iff (!reset_n)
		!interrupt_ack_strobe_n |-> ({io_mem_select,
		transceiver_direction, status_zero_line} == bus_ctl_pkg::STAT_INTERRUPT_ACK_STROBE_N))
		else $error("ack strobe without ack status");

endmodule : min_mode_bus_control

// File: testbench/bus_far_side.sv
// Purpose: far side model: address latch, ready source, other bus master
// Assumes: bench controls change on the falling edge of mclk
// Notes:   wait count is set by the bench before each cycle starts
`timescale 1ns/1ps
module bus_far_side (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       reset_n,
	// lines seen at the pins
	input  wire logic       address_latch_pulse,
	input  wire logic [2:0] status_wire,
	// bench controls
	input  wire logic [3:0] wait_states,
	input  wire logic       want_bus,
	// answers
	output logic            ready,
	output logic            hold_request,
	output logic [2:0]      latched_status
);
	int since_reg;

	// latch closes as the pulse falls; count cycles since the pulse
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			latched_status <= 3'h7;
			since_reg      <= 100;
		end else if (address_latch_pulse) begin
			latched_status <= status_wire;
			since_reg      <= 1;
		end else if (since_reg < 100) begin
			since_reg <= since_reg + 1;
		end
	end

	// request held, changed off the sampling edge
	// ready stays low until the wanted wait states have run
	always_ff @(negedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ready        <= 1'b1;
			hold_request <= 1'b0;
		end else begin
			ready        <= (since_reg >= 4 + 2 * int'(wait_states));
			hold_request <= want_bus;
		end
	end
endmodule : bus_far_side

// File: testbench/min_mode_bus_control_tb.sv
// Purpose: self-checking bench for the minimum-mode bus control block
// Assumes: two mclk cycles per T state, inputs driven at falling edge
// Notes:   floated lines read as level one through the bus keepers
`timescale 1ns/1ps
module min_mode_bus_control_tb;
	logic mclk = 1'b0;
	logic rst_n, mode, req, rdy, hreq, want, acc, done, grant, ale;
	logic io, io_oe, wr_n, wr_oe, rd_n, rd_oe, ak_n, dir, dir_oe;
	logic en_n, en_oe, s0, s0_oe;
	bus_ctl_pkg::cycle_kind_t kind;
	logic [3:0]  waits;
	logic [2:0]  latched, pat_w;
	logic [5:0]  oes;
	logic [2:0]  pat_tab [8] = '{3'h4, 3'h5, 3'h6, 3'h7,
		3'h0, 3'h1, 3'h2, 3'h3};
	logic [2:0]  exp_q [$];
	int          error_cnt = 0;
	int          n_compared = 0;
	int          n;

	always #20 mclk = ~mclk;
	// wire levels with keepers holding one when floated
	assign pat_w = {io_oe ? io : 1'b1, dir_oe ? dir : 1'b1, s0_oe ? s0 : 1'b1};
	assign oes = {io_oe, wr_oe, rd_oe, dir_oe, en_oe, s0_oe};

	min_mode_bus_control i_min_mode_bus_control (.mclk(mclk), .reset_n(rst_n),
		.min_max_mode_select(mode), .cycle_request(req), .cycle_kind(kind),
		.ready(rdy), .cycle_accept(acc), .cycle_done(done),
		.hold_request(hreq), .bus_hold_grant(grant), .io_mem_select(io),
		.io_mem_select_oe(io_oe), .write_strobe_n(wr_n),
		.write_strobe_n_oe(wr_oe), .read_strobe_n(rd_n),
		.read_strobe_n_oe(rd_oe), .interrupt_ack_strobe_n(ak_n),
		.transceiver_direction(dir), .transceiver_direction_oe(dir_oe),
		.transceiver_output_enable_n(en_n),
		.transceiver_output_enable_n_oe(en_oe), .status_zero_line(s0),
		.status_zero_line_oe(s0_oe), .address_latch_pulse(ale));

	bus_far_side i_bus_far_side (.mclk(mclk), .reset_n(rst_n),
		.address_latch_pulse(ale), .status_wire(pat_w), .wait_states(waits),
		.want_bus(want), .ready(rdy), .hold_request(hreq),
		.latched_status(latched));

	// one compare point so every mismatch is counted alike
	task automatic check(input string what, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	// bounded wait at falling edges for a flag to reach a level
	task automatic wait_for(ref logic flag, input logic lvl, input int lim);
		n = 0;
		while (flag !== lvl) begin
			@(negedge mclk);
			#1;
			n++;
			if (n > lim) begin
				error_cnt++;
				$display("unexpected wait: expected %h seen %h", lvl, flag);
				conclude();
			end
		end
	endtask : wait_for

	// one bus cycle against the reference timing, entered at a falling edge
	task automatic run_cycle(input int k_in, input int w);
		int len;
		logic wr, rd, ak, st, en;
		len = 8 + 2 * w;
		waits = w[3:0];
		exp_q.push_back(pat_tab[k_in]);
		kind = bus_ctl_pkg::cycle_kind_t'(k_in);
		req = 1'b1;
		#1;
		wait_for(acc, 1'b1, 40);
		for (int k = 1; k <= len; k++) begin
			@(negedge mclk);
			req = 1'b0;
			st = (k >= 3) && (k <= len - 2);
			wr = st && (k_in == 2 || k_in == 6);
			rd = st && (k_in == 1 || k_in == 4 || k_in == 5);
			ak = st && (k_in == 0);
			// enable stays on through the first half of T4
			en = (k <= len - 1) && (((k_in == 2 || k_in == 6) && k >= 3) ||
				((k_in inside {0, 1, 4, 5}) && k >= 4));
			#1;
			check("bus lines", {done, oes, io, dir, s0, ale, wr_n, rd_n, ak_n,
				en_n}, {k == len - 1, 6'h3f, pat_tab[k_in], k == 2, ~wr, ~rd,
				~ak, ~en});
		end
		check("latched status", {13'h0, latched}, {13'h0, exp_q.pop_front()});
	endtask : run_cycle

	initial begin
		rst_n = 1'b0;
		mode  = 1'b0;
		req   = 1'b0;
		want  = 1'b0;
		waits = 4'h0;
		kind  = bus_ctl_pkg::KIND_PASSIVE;
		void'($urandom(39142));
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		// maximum mode strap: all lines with an output enable floated, requests ignored
		req = 1'b1;
		repeat (4) begin
			@(negedge mclk);
			check("max mode", {acc, oes, pat_w}, {1'b0, 6'h0, 3'h7});
		end
		mode = 1'b1;
		req  = 1'b0;
		@(negedge mclk);
		// every kind once, back to back
		for (int i = 0; i < 8; i++) begin
			run_cycle(i, 0);
		end
		repeat (12) begin
			run_cycle($urandom_range(7, 0), $urandom_range(2, 0));
		end
		// another master takes the bus; core requests are refused meanwhile
		want <= 1'b1;
		#1;
		wait_for(grant, 1'b1, 8);
		req  = 1'b1;
		kind = bus_ctl_pkg::KIND_MEM_READ;
		repeat (6) begin
			@(negedge mclk);
			#1;
			check("hold float", {acc, grant, ak_n, oes, pat_w},
				{1'b0, 1'b1, 1'b1, 6'h0, 3'h7});
		end
		@(negedge mclk);
		req = 1'b0;
		want <= 1'b0;
		#1;
		// grant drops soon after request low
		wait_for(grant, 1'b0, 4);
		@(negedge mclk);
		#1;
		check("released float", {grant, oes, pat_w}, {1'b0, 6'h0, 3'h7});
		run_cycle(6, 1);
		conclude();
	end
endmodule : min_mode_bus_control_tb
